/* iolp_map.svh */
// register map and timing constants of the interrupt option and low-power controller
`ifndef IOLP_MAP_SVH
`define IOLP_MAP_SVH
`define IOLP_OPTION_ADDR 12'h0C8
`define IOLP_OPTION_RESET 8'h00
`define IOLP_LEVEL_BIT 6
`define IOLP_POLARITY_BIT 5
`define IOLP_GLOBAL_BIT 4
`define IOLP_OPTION_MASK 8'h70
`define IOLP_STATUS_ADDR 12'h0CC
`define IOLP_STAB_CYCLES 4096
`endif

/* iolp_pkg.sv */
// types of the interrupt option and low-power controller
package iolp_pkg;
    typedef enum logic [3:0] {
        IOLP_RUN = 4'h1,
        IOLP_WAIT = 4'h2,
        IOLP_STOP = 4'h4,
        IOLP_STAB = 4'h8
    } iolp_mode_t;
    typedef enum logic [1:0] {
        IOLP_CTX_NORMAL = 2'h0,
        IOLP_CTX_IRQ = 2'h1,
        IOLP_CTX_NMI = 2'h2
    } iolp_ctx_t;
endpackage

/* iolp_ctrl.sv */
// interrupt option register, request latches and wait/stop sequencing
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iolp_map.svh"
module iolp_ctrl #(
    parameter int STAB_CYCLES = `IOLP_STAB_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_n,
    input wire logic src1_n,
    input wire logic src2,
    input wire logic [1:0] src34_n,
    input wire logic instr_done,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic [2:0] service_start,
    input wire iolp_pkg::iolp_ctx_t core_ctx,
    input wire logic watchdog_active,
    output logic [4:0] irq_pending,
    output logic wake,
    output logic wake_service,
    output logic core_halted,
    output logic osc_stop,
    output logic entry_refused,
    output logic source1_level_select,
    output logic source2_polarity_select,
    output logic global_irq_enable
);
    import iolp_pkg::*;

    initial begin
        if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin
            $error("STAB_CYCLES out of range");
        end
    end

    typedef struct packed {
        logic [7:0] option;
        logic [2:0] s1_sync;
        logic [2:0] s2_sync;
        logic [2:0] nmi_sync;
        logic [5:0] s34_sync;
        logic s1_lvl;
        logic s2_lvl;
        logic nmi_lvl;
        logic nmi_latch;
        logic s1_latch;
        logic s2_latch;
        logic [4:0] pend;
        iolp_mode_t mode;
        iolp_ctx_t ctx;
        logic [15:0] stab_cnt;
        logic wake;
        logic wake_service;
        logic refused;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iolp_state_t;

    iolp_state_t r;
    iolp_state_t next_r;
    logic s1_now, s1_prev, s2_now, s2_prev, nmi_now, nmi_prev;
    logic s1_fall, s2_rise, s2_fall, nmi_fall;
    logic [4:0] req;
    logic any_enabled;
    logic wake_req;
    logic setup;

    // settled views of the synchronised lines: second and third stages agree
    function automatic logic settled(input logic [2:0] s, input logic old);
        settled = (s[1] == s[2]) ? s[1] : old;
    endfunction

    always_comb begin
        next_r = r;
        // held settled levels; an edge is a change of the held level
        s1_prev = r.s1_lvl;
        s2_prev = r.s2_lvl;
        nmi_prev = r.nmi_lvl;
        s1_now = settled(r.s1_sync, s1_prev);
        s2_now = settled(r.s2_sync, s2_prev);
        nmi_now = settled(r.nmi_sync, nmi_prev);
        next_r.s1_lvl = s1_now;
        next_r.s2_lvl = s2_now;
        next_r.nmi_lvl = nmi_now;
        s1_fall = s1_prev & ~s1_now;
        s2_rise = ~s2_prev & s2_now;
        s2_fall = s2_prev & ~s2_now;
        nmi_fall = nmi_prev & ~nmi_now;
        // three-stage synchronisers for pins
        next_r.s1_sync = {r.s1_sync[1:0], src1_n};
        next_r.s2_sync = {r.s2_sync[1:0], src2};
        next_r.nmi_sync = {r.nmi_sync[1:0], nmi_n};
        next_r.s34_sync = {r.s34_sync[3:0], src34_n};
        // edge latches; a new edge wins over a service clear
        if (service_start == 3'h0) next_r.nmi_latch = 1'b0;
        if (service_start == 3'h1) next_r.s1_latch = 1'b0;
        if (service_start == 3'h2) next_r.s2_latch = 1'b0;
        if (nmi_fall) next_r.nmi_latch = 1'b1;
        if (!r.option[`IOLP_LEVEL_BIT] && s1_fall) next_r.s1_latch = 1'b1;
        if (r.option[`IOLP_POLARITY_BIT] ? s2_rise : s2_fall) next_r.s2_latch = 1'b1;
        // raw requests; level ones are the low line itself
        req[0] = r.nmi_latch;
        req[1] = r.option[`IOLP_LEVEL_BIT] ? ~s1_now : r.s1_latch;
        req[2] = r.s2_latch;
        req[3] = ~(r.s34_sync[3] | r.s34_sync[5]) & (r.s34_sync[3] == r.s34_sync[5]);
        req[4] = ~(r.s34_sync[4] | r.s34_sync[2]) & (r.s34_sync[4] == r.s34_sync[2]);
        // maskable sources gated by the global enable
        req[4:1] = req[4:1] & {4{r.option[`IOLP_GLOBAL_BIT]}};
        any_enabled = |req;
        // the whole enable also gates wake-up, nmi included
        wake_req = r.option[`IOLP_GLOBAL_BIT] & any_enabled;
        // sample pending lines after each instruction
        if (instr_done) next_r.pend = req;
        next_r.wake = 1'b0;
        next_r.wake_service = 1'b0;
        next_r.refused = 1'b0;
        case (r.mode)
            IOLP_RUN: begin
                if ((wait_exec || stop_exec) && any_enabled) begin
                    next_r.refused = 1'b1;
                end else if (stop_exec && !watchdog_active) begin
                    next_r.mode = IOLP_STOP;
                    next_r.ctx = core_ctx;
                end else if (wait_exec || stop_exec) begin
                    next_r.mode = IOLP_WAIT;
                    next_r.ctx = core_ctx;
                end
            end
            IOLP_WAIT: begin
                if (wake_req) begin
                    next_r.mode = IOLP_RUN;
                    next_r.wake = 1'b1;
                    // service decision by entry context
                    next_r.wake_service = (r.ctx == IOLP_CTX_NORMAL) |
                        ((r.ctx == IOLP_CTX_IRQ) & req[0]);
                    next_r.pend = req;
                end
            end
            IOLP_STOP: begin
                if (wake_req) begin
                    next_r.mode = IOLP_STAB;
                    next_r.stab_cnt = 16'(STAB_CYCLES - 1);
                end
            end
            IOLP_STAB: begin
                if (r.stab_cnt == 16'h0000) begin
                    next_r.mode = IOLP_RUN;
                    next_r.wake = 1'b1;
                    next_r.wake_service = (r.ctx == IOLP_CTX_NORMAL) |
                        ((r.ctx == IOLP_CTX_IRQ) & req[0]);
                    next_r.pend = req;
                end else begin
                    next_r.stab_cnt = r.stab_cnt - 16'h0001;
                end
            end
            default: next_r.mode = IOLP_RUN;
        endcase
        // apb slave: zero-wait answer in the access cycle
        setup = psel & ~penable;
        next_r.pready = setup;
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000; // option register reads as zero
        // the write lands at the edge that closes the access phase
        if (psel && penable && r.pready && pwrite && paddr == `IOLP_OPTION_ADDR) begin
            next_r.option = pwdata[7:0] & `IOLP_OPTION_MASK;
        end
        if (setup) begin
            if (paddr == `IOLP_OPTION_ADDR) begin
                next_r.pslverr = 1'b0;
            end else if (paddr == `IOLP_STATUS_ADDR) begin
                if (!pwrite) next_r.prdata = {23'h000000, r.pend, r.mode};
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
    end

    // single state register; reset clears options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.option <= `IOLP_OPTION_RESET;
            r.s1_sync <= 3'h7;
            r.s2_sync <= 3'h0;
            r.nmi_sync <= 3'h7;
            r.s1_lvl <= 1'b1;
            r.nmi_lvl <= 1'b1;
            r.s34_sync <= 6'h3F;
            r.mode <= IOLP_RUN;
            r.ctx <= IOLP_CTX_NORMAL;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state; oscillator select is not touched here
    always_comb begin
        prdata = r.prdata;
        pready = r.pready;
        pslverr = r.pslverr;
        irq_pending = r.pend;
        wake = r.wake;
        wake_service = r.wake_service;
        core_halted = (r.mode != IOLP_RUN);
        osc_stop = (r.mode == IOLP_STOP);
        entry_refused = r.refused;
        source1_level_select = r.option[`IOLP_LEVEL_BIT];
        source2_polarity_select = r.option[`IOLP_POLARITY_BIT];
        global_irq_enable = r.option[`IOLP_GLOBAL_BIT];
    end

    sequence s_stop_wake;
        (r.mode == IOLP_STOP) && wake_req;
    endsequence

    AST_STOP_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        s_stop_wake |=> (r.mode == IOLP_STAB) [*1] ##0 !r.wake)
        else $error("stop wake skipped stabilisation");
    AST_WAIT_NODELAY: assert property (@(posedge pclk) disable iff (!presetn)
        (r.mode == IOLP_WAIT && wake_req) |=> r.wake && r.mode == IOLP_RUN)
        else $error("wait wake delayed");
    AST_NO_WAKE_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        (r.mode == IOLP_WAIT && !r.option[`IOLP_GLOBAL_BIT]) |=> r.mode == IOLP_WAIT)
        else $error("woke with enable clear");
    AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
        (r.mode == IOLP_RUN && wait_exec && any_enabled) |=> r.refused && r.mode == IOLP_RUN)
        else $error("entered low power with request pending");
    AST_WDOG_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (r.mode == IOLP_RUN && stop_exec && watchdog_active && !any_enabled) |=> r.mode == IOLP_WAIT)
        else $error("stop executed under watchdog");
    AST_NMI_CTX: assert property (@(posedge pclk) disable iff (!presetn)
        (r.ctx == IOLP_CTX_NMI && r.mode == IOLP_WAIT && wake_req) |=> !r.wake_service)
        else $error("service in nmi context");
    AST_NORMAL_CTX: assert property (@(posedge pclk) disable iff (!presetn)
        (r.ctx == IOLP_CTX_NORMAL && r.mode == IOLP_WAIT && wake_req) |=> r.wake_service)
        else $error("no service from normal context");
    AST_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `IOLP_OPTION_ADDR) |=> pready && prdata == 32'h0000_0000)
        else $error("option register readable");
    AST_S1_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        (r.option[`IOLP_LEVEL_BIT] && r.option[`IOLP_GLOBAL_BIT] && instr_done) |=> r.pend[1] == $past(~s1_now))
        else $error("level source misread");
endmodule
`default_nettype wire

/* iolp_core_model.sv */
// core and request pin model that faces the low-power controller
`timescale 1ns/1ps
`default_nettype none
module iolp_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_halted,
    output var logic nmi_n,
    output var logic src1_n,
    output var logic src2,
    output var logic [1:0] src34_n,
    output var logic instr_done,
    output var logic wait_exec,
    output var logic stop_exec,
    output var logic [2:0] service_start,
    output var iolp_pkg::iolp_ctx_t core_ctx,
    output var logic watchdog_active
);
    import iolp_pkg::*;
    logic [1:0] cnt;
    // idle pins, the bench moves them later
    initial begin
        nmi_n = 1'b1;
        src1_n = 1'b1;
        src2 = 1'b1;
        src34_n = 2'h3;
        wait_exec = 1'b0;
        stop_exec = 1'b0;
        service_start = 3'h7;
        core_ctx = IOLP_CTX_NORMAL;
        watchdog_active = 1'b0;
    end
    // one instruction every four cycles, none while fetch is halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            instr_done <= !core_halted && cnt == 2'h3;
        end
    end
endmodule
`default_nettype wire

/* tb_iolp_ctrl.sv */
// self-checking bench of the interrupt option and low-power controller
`timescale 1ns/1ps
`default_nettype none
module tb_iolp_ctrl;
    import iolp_pkg::*;
    localparam int STAB = 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] irq_pending;
    logic wake, wake_service, core_halted, osc_stop, entry_refused, lvl, pol, gen, er, ws;
    logic nmi_n, src1_n, src2, instr_done, wait_exec, stop_exec, wd;
    logic [1:0] src34_n;
    logic [2:0] service_start;
    iolp_ctx_t core_ctx;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    iolp_core_model core (.pclk(pclk), .presetn(presetn), .core_halted(core_halted), .nmi_n(nmi_n),
        .src1_n(src1_n), .src2(src2), .src34_n(src34_n), .instr_done(instr_done), .wait_exec(wait_exec),
        .stop_exec(stop_exec), .service_start(service_start), .core_ctx(core_ctx), .watchdog_active(wd));
    iolp_ctrl #(.STAB_CYCLES(STAB)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmi_n(nmi_n), .src1_n(src1_n), .src2(src2), .src34_n(src34_n), .instr_done(instr_done),
        .wait_exec(wait_exec), .stop_exec(stop_exec), .service_start(service_start), .core_ctx(core_ctx),
        .watchdog_active(wd), .irq_pending(irq_pending), .wake(wake), .wake_service(wake_service),
        .core_halted(core_halted), .osc_stop(osc_stop), .entry_refused(entry_refused),
        .source1_level_select(lvl), .source2_polarity_select(pol), .global_irq_enable(gen));
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) chk(0, 1);
        @(posedge pclk);
    endtask
    task automatic svc(input logic [2:0] s);
        core.service_start <= s;
        @(posedge pclk);
        core.service_start <= 3'h7;
        cyc(3);
    endtask
    task automatic enter(input logic stp, input logic exp_osc);
        if (stp) core.stop_exec <= 1'b1;
        else core.wait_exec <= 1'b1;
        @(posedge pclk);
        core.stop_exec <= 1'b0;
        core.wait_exec <= 1'b0;
        cyc(3);
        chk(core_halted, 1);
        chk(osc_stop, exp_osc);
    endtask
    task automatic wake_wait();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (wake !== 1'b1 && n < 200);
        ws = wake_service;
        if (n >= 200) chk(0, 1);
        cyc(2);
        chk(core_halted, 0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(20 * 5000);
        miscompares++;
        end_sim();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cyc(16);
        presetn <= 1'b1;
        cyc(4);
        chk({lvl, pol, gen}, 3'h0);
        apb(1'b1, 12'h0C8, 32'h0000_0070);
        chk({lvl, pol, gen}, 3'h7);
        apb(1'b0, 12'h0C8, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0D0, 32'h0);
        chk(er, 1);
        $display("test registers done");
        apb(1'b1, 12'h0C8, 32'h0000_0010);
        core.src1_n <= 1'b0;
        core.src2 <= 1'b0;
        cyc(12);
        chk(irq_pending[2:1], 2'h3);
        core.src1_n <= 1'b1;
        svc(3'h1);
        svc(3'h2);
        cyc(8);
        chk(irq_pending[2:1], 2'h0);
        apb(1'b1, 12'h0C8, 32'h0000_0050);
        core.src1_n <= 1'b0;
        cyc(12);
        chk(irq_pending[1], 1);
        core.src1_n <= 1'b1;
        cyc(12);
        chk(irq_pending[1], 0);
        $display("test sensing done");
        apb(1'b1, 12'h0C8, 32'h0000_0030);
        enter(1'b0, 1'b0);
        core.src2 <= 1'b1;
        wake_wait();
        chk(ws, 1);
        chk(n <= 8, 1);
        svc(3'h2);
        apb(1'b1, 12'h0C8, 32'h0000_0010);
        enter(1'b1, 1'b1);
        core.src1_n <= 1'b0;
        wake_wait();
        chk(n >= STAB + 1, 1);
        chk(osc_stop, 0);
        core.src1_n <= 1'b1;
        svc(3'h1);
        $display("test wait stop done");
        for (int c = 0; c < 3; c++) begin
            core.core_ctx <= iolp_ctx_t'(c);
            enter(1'b0, 1'b0);
            core.nmi_n <= 1'b0;
            wake_wait();
            chk(ws, c != 2);
            core.nmi_n <= 1'b1;
            svc(3'h0);
        end
        core.core_ctx <= IOLP_CTX_IRQ;
        apb(1'b1, 12'h0C8, 32'h0000_0030);
        core.src2 <= 1'b0;
        enter(1'b0, 1'b0);
        core.src2 <= 1'b1;
        wake_wait();
        chk(ws, 0);
        svc(3'h2);
        core.core_ctx <= IOLP_CTX_NORMAL;
        core.watchdog_active <= 1'b1;
        cyc(2);
        enter(1'b1, 1'b0);
        core.nmi_n <= 1'b0;
        wake_wait();
        core.nmi_n <= 1'b1;
        svc(3'h0);
        core.watchdog_active <= 1'b0;
        $display("test contexts done");
        core.nmi_n <= 1'b0;
        cyc(12);
        core.wait_exec <= 1'b1;
        @(posedge pclk);
        core.wait_exec <= 1'b0;
        ws = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            if (entry_refused === 1'b1) ws = 1'b1;
        end
        chk({ws, core_halted}, 2'h2);
        core.nmi_n <= 1'b1;
        svc(3'h0);
        apb(1'b1, 12'h0C8, 32'h0000_0000);
        enter(1'b0, 1'b0);
        core.nmi_n <= 1'b0;
        cyc(40);
        chk(core_halted, 1);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        core.nmi_n <= 1'b1;
        cyc(4);
        chk({core_halted, lvl, pol, gen}, 4'h0);
        $display("test refusal and reset done");
        end_sim();
    end
endmodule
`default_nettype wire
